/* File: core/imu_core.sv */
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module imu_core (
  input  wire logic                  ref_clk,         // 10 MHz clock
  input  wire logic                  rst,             // synchronous reset
  input  wire logic                  psel,            // apb select
  input  wire logic                  penable,         // apb enable
  input  wire logic                  pwrite,          // apb direction
  input  wire logic [11:0]           paddr,           // apb byte address
  input  wire logic [31:0]           pwdata,          // apb write data
  output logic      [31:0]           prdata,          // apb read data
  output logic                       pready,          // apb ready
  output logic                       pslverr,         // apb error
  input  wire logic                  pci_req_valid,   // pci target request held
  input  wire imu_pkg::imu_pci_req_t pci_req,         // pci target request
  output imu_pkg::imu_pci_rsp_t      pci_rsp,         // pci target answer
  output imu_pkg::imu_mem_req_t      mem_req,         // local memory request
  input  wire logic                  mem_ack,         // local memory done pulse
  input  wire logic [31:0]           mem_rdata,       // local memory read data
  output logic                       pci_int,         // pci interrupt, high active
  output logic                       lb_int,          // local interrupt, high active
  output logic                       msg_mode,        // message mode active
  output logic      [7:0]            cfg_regbase_off  // config offset of register bar
);

  typedef enum {ST_IDLE, ST_MEM, ST_ACK} imu_state_t;

  // ************************************************************
  // state
  // ************************************************************
  imu_state_t            state_q;
  imu_state_t            state_d;
  logic [31:0]           ctrl_q;
  logic [31:0]           ctrl_d;
  logic                  ipn_en_q;
  logic                  ipn_en_d;
  logic                  op_mask_q;
  logic                  op_mask_d;
  logic                  new_q;
  logic                  new_d;
  logic                  opi_q;
  logic                  opi_d;
  logic [1:0]            job_q;
  logic [1:0]            job_d;
  logic                  job_rd_q;
  logic                  job_rd_d;
  logic [31:0]           prdata_q;
  logic [31:0]           prdata_d;
  logic                  pready_q;
  logic                  pready_d;
  logic                  pslverr_q;
  logic                  pslverr_d;
  imu_pkg::imu_pci_rsp_t rsp_q;
  imu_pkg::imu_pci_rsp_t rsp_d;
  imu_pkg::imu_mem_req_t mem_q;
  imu_pkg::imu_mem_req_t mem_d;
  logic                  pci_int_q;
  logic                  pci_int_d;
  logic                  lb_int_q;
  logic                  lb_int_d;
  logic [7:0]            cfg_off_q;
  logic [7:0]            cfg_off_d;

  logic [19:0]           top_ptr [4];
  logic [19:0]           bot_ptr [4];
  logic [3:0]            q_empty;
  logic [3:0]            q_full;
  logic [3:0]            sw_top_we;
  logic [3:0]            sw_bot_we;
  logic [3:0]            adv_top;
  logic [3:0]            adv_bot;

  logic [2:0]            size_sel;
  logic [11:0]           base_hi;
  logic                  apb_commit;
  logic                  apb_word;
  logic                  apb_ptr_hit;
  logic [3:0]            apb_ptr_idx;

  // ************************************************************
  // decode
  // ************************************************************
  assign size_sel    = ctrl_q[imu_pkg::CTRL_SIZE_LSB +: 3];
  assign base_hi     = ctrl_q[imu_pkg::CTRL_BASE_LSB +: 12];
  // a write takes effect only at the edge that samples ready high
  assign apb_commit  = psel && penable && pready_q;
  // unaligned addresses must not alias onto a pointer register
  assign apb_word    = (paddr[1:0] == 2'h0);
  assign apb_ptr_hit = apb_word && (paddr >= imu_pkg::APB_PTR_LO) &&
                       (paddr <= imu_pkg::APB_PTR_HI);
  assign apb_ptr_idx = 4'(paddr[5:2] - imu_pkg::APB_PTR_LO[5:2]);

  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign pci_rsp         = rsp_q;
  assign mem_req         = mem_q;
  assign pci_int         = pci_int_q;
  assign lb_int          = lb_int_q;
  assign msg_mode        = ctrl_q[imu_pkg::CTRL_EN_BIT];
  assign cfg_regbase_off = cfg_off_q;

  // a port read drains one list of the pair, a port write fills the other
  function automatic logic [1:0] port_queue(input logic in_port,
                                            input logic we);
    if (in_port) begin
      return we ? 2'(imu_pkg::Q_IN_POST) : 2'(imu_pkg::Q_IN_FREE);
    end
    return we ? 2'(imu_pkg::Q_OUT_FREE) : 2'(imu_pkg::Q_OUT_POST);
  endfunction

  // ************************************************************
  // pointer queues
  // ************************************************************
  for (genvar i = 0; i < 4; i++) begin : g_queue
    imu_queue u_queue (
      .ref_clk    (ref_clk),
      .rst        (rst),
      .size_sel   (size_sel),
      .sw_top_we  (sw_top_we[i]),
      .sw_bot_we  (sw_bot_we[i]),
      .sw_ptr     (pwdata[19:0]),
      .hw_adv_top (adv_top[i]),
      .hw_adv_bot (adv_bot[i]),
      .top_ptr    (top_ptr[i]),
      .bot_ptr    (bot_ptr[i]),
      .empty      (q_empty[i]),
      .full       (q_full[i])
    );
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    state_d   = state_q;
    ctrl_d    = ctrl_q;
    ipn_en_d  = ipn_en_q;
    op_mask_d = op_mask_q;
    new_d     = new_q;
    job_d     = job_q;
    job_rd_d  = job_rd_q;
    prdata_d  = prdata_q;
    pslverr_d = pslverr_q;
    rsp_d     = rsp_q;
    rsp_d.ack = 1'b0;
    mem_d     = mem_q;
    sw_top_we = 4'h0;
    sw_bot_we = 4'h0;
    adv_top   = 4'h0;
    adv_bot   = 4'h0;

    // apb slave: one wait state, the write lands at the ready edge
    pready_d = psel && penable && !pready_q;
    if (pready_d) begin
      pslverr_d = 1'b0;
      prdata_d  = 32'h0000_0000;
      if (paddr == imu_pkg::APB_CTRL) begin
        prdata_d = ctrl_q;
      end else if (paddr == imu_pkg::APB_STAT) begin
        prdata_d[3:0]                  = q_empty;
        prdata_d[7:4]                  = q_full;
        prdata_d[imu_pkg::STAT_NEW_BIT] = new_q;
        prdata_d[imu_pkg::STAT_OPI_BIT] = opi_q;
      end else if (paddr == imu_pkg::APB_INTEN) begin
        prdata_d[imu_pkg::INTEN_IPN_BIT] = ipn_en_q;
        prdata_d[imu_pkg::INTEN_OPM_BIT] = op_mask_q;
      end else if (apb_ptr_hit) begin
        prdata_d = {base_hi, apb_ptr_idx[0] ? top_ptr[apb_ptr_idx[2:1]]
                                            : bot_ptr[apb_ptr_idx[2:1]]};
      end else begin
        pslverr_d = 1'b1;
      end
    end

    if (apb_commit && pwrite) begin
      if (paddr == imu_pkg::APB_CTRL) begin
        ctrl_d = pwdata;
      end else if (paddr == imu_pkg::APB_STAT) begin
        if (pwdata[imu_pkg::STAT_NEW_BIT]) begin
          new_d = 1'b0;
        end
      end else if (paddr == imu_pkg::APB_INTEN) begin
        ipn_en_d  = pwdata[imu_pkg::INTEN_IPN_BIT];
        op_mask_d = pwdata[imu_pkg::INTEN_OPM_BIT];
      end else if (apb_ptr_hit) begin
        sw_top_we[apb_ptr_idx[2:1]] = apb_ptr_idx[0];
        sw_bot_we[apb_ptr_idx[2:1]] = !apb_ptr_idx[0];
      end
    end

    // pci side of the message region
    case (state_q)
      ST_IDLE: begin
        if (pci_req_valid) begin
          state_d      = ST_ACK;
          rsp_d.ack    = 1'b1;
          rsp_d.retry  = 1'b0;
          rsp_d.fwd    = 1'b0;
          rsp_d.data   = 32'h0000_0000;
          job_rd_d     = !pci_req.we;
          // region closed: the requester must come back, nothing is queued
          if (!ctrl_q[imu_pkg::CTRL_EN_BIT] || ctrl_q[imu_pkg::CTRL_DIS_BIT]) begin
            rsp_d.retry = 1'b1;
          end else if (pci_req.off >= imu_pkg::MU_LOW_LIMIT) begin
            rsp_d.fwd = 1'b1;
          end else if ((pci_req.off == imu_pkg::MU_IN_PORT) ||
                       (pci_req.off == imu_pkg::MU_OUT_PORT)) begin
            job_d = port_queue(pci_req.off == imu_pkg::MU_IN_PORT, pci_req.we);
            if (!pci_req.we && q_empty[job_d]) begin
              rsp_d.data = imu_pkg::MU_EMPTY_DATA;
            end else if (!(pci_req.we && q_full[job_d])) begin
              // a post into a full queue is dropped, the write still completes
              state_d    = ST_MEM;
              rsp_d.ack  = 1'b0;
              mem_d.valid = 1'b1;
              mem_d.we    = pci_req.we;
              mem_d.data  = pci_req.data;
              mem_d.addr  = {base_hi, pci_req.we ? top_ptr[job_d] : bot_ptr[job_d]};
            end
          end else if (pci_req.off == imu_pkg::MU_SYS_INT_STAT) begin
            rsp_d.data[imu_pkg::MU_OPI_BIT] = opi_q;
          end else if (pci_req.off == imu_pkg::MU_SYS_INT_MASK) begin
            rsp_d.data[imu_pkg::MU_OPI_BIT] = op_mask_q;
            if (pci_req.we) begin
              op_mask_d = pci_req.data[imu_pkg::MU_OPI_BIT];
            end
          end
        end
      end

      ST_MEM: begin
        // the pci answer waits for the memory cycle
        if (mem_ack) begin
          state_d     = ST_ACK;
          mem_d.valid = 1'b0;
          rsp_d.ack   = 1'b1;
          if (job_rd_q) begin
            rsp_d.data     = mem_rdata;
            adv_bot[job_q] = 1'b1;
          end else begin
            adv_top[job_q] = 1'b1;
            if (job_q == 2'(imu_pkg::Q_IN_POST)) begin
              new_d = 1'b1;
            end
          end
        end
      end

      default: begin
        // one idle cycle so a request still held at the ack edge is not retaken
        state_d = ST_IDLE;
      end
    endcase

    // outbound-post status and pci interrupt follow the queue state one edge later; lb_int moves with new
    opi_d     = !q_empty[imu_pkg::Q_OUT_POST];
    pci_int_d = opi_d && !op_mask_d;
    lb_int_d  = new_d && ipn_en_d;
    cfg_off_d = ctrl_d[imu_pkg::CTRL_EN_BIT] ? imu_pkg::CFG_BAR_MOVED
                                             : imu_pkg::CFG_BAR_FIRST;
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q   <= ST_IDLE;
      ctrl_q    <= imu_pkg::CTRL_RESET;
      ipn_en_q  <= 1'b0;
      op_mask_q <= 1'b0;
      new_q     <= 1'b0;
      opi_q     <= 1'b0;
      job_q     <= 2'h0;
      job_rd_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      rsp_q     <= '0;
      mem_q     <= '0;
      pci_int_q <= 1'b0;
      lb_int_q  <= 1'b0;
      cfg_off_q <= imu_pkg::CFG_BAR_FIRST;
    end else begin
      state_q   <= state_d;
      ctrl_q    <= ctrl_d;
      ipn_en_q  <= ipn_en_d;
      op_mask_q <= op_mask_d;
      new_q     <= new_d;
      opi_q     <= opi_d;
      job_q     <= job_d;
      job_rd_q  <= job_rd_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      rsp_q     <= rsp_d;
      mem_q     <= mem_d;
      pci_int_q <= pci_int_d;
      lb_int_q  <= lb_int_d;
      cfg_off_q <= cfg_off_d;
    end
  end

endmodule

/* File: core/imu_pkg.sv */
// Behaviour
// - keep top and bottom pointer per queue, offsets from a 1 Mbyte aligned base
// - add stores at the top pointer, remove takes from the bottom pointer
// - PCI write to port 0x040 posts frame address at inbound-post top, local interrupt
// - PCI read of 0x040 returns inbound-free bottom entry, all ones when empty
// - PCI read of 0x044 returns outbound-post bottom entry, all ones when empty
// - PCI write to 0x044 stores frame address at outbound-free top
// - PCI interrupt, when unmasked, while outbound-post queue holds entries
// - message mode moves register-access base from config 0x010 to 0x018
// - low 4 Kbytes of message region never forwarded; above goes to image 0
// - low offsets 0x030/0x034 serve interrupts, 0x040/0x044 are the queue ports
// - all queues inside one 1 Mbyte window sharing address bits 31..20
// - equal top and bottom at start-up mean empty
// - each outbound-free port write into a non-full queue advances outbound-free top by 4 bytes
// - unit pointer advances wrap modulo the queue size
// - no top advance when full, no bottom advance when empty
// - writing 1 clears inbound-post new status and its local interrupt
// - outbound-post status clears when that queue empties after a port read
package imu_pkg;

  // ************************************************************
  // apb register map
  // ************************************************************
  localparam logic [11:0] APB_CTRL   = 12'h000;
  localparam logic [11:0] APB_STAT   = 12'h004;
  localparam logic [11:0] APB_INTEN  = 12'h008;
  localparam logic [11:0] APB_PTR_LO = 12'h010;
  localparam logic [11:0] APB_PTR_HI = 12'h02c;

  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_DIS_BIT  = 1;
  localparam int unsigned CTRL_SIZE_LSB = 4;
  localparam int unsigned CTRL_BASE_LSB = 20;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0002;
  localparam int unsigned STAT_NEW_BIT  = 8;
  localparam int unsigned STAT_OPI_BIT  = 9;
  localparam int unsigned INTEN_IPN_BIT = 0;
  localparam int unsigned INTEN_OPM_BIT = 1;

  // ************************************************************
  // queues and message region
  // ************************************************************
  localparam int unsigned Q_IN_FREE  = 0;
  localparam int unsigned Q_IN_POST  = 1;
  localparam int unsigned Q_OUT_POST = 2;
  localparam int unsigned Q_OUT_FREE = 3;

  localparam logic [19:0] MU_SYS_INT_STAT = 20'h0_0030;
  localparam logic [19:0] MU_SYS_INT_MASK = 20'h0_0034;
  localparam logic [19:0] MU_IN_PORT      = 20'h0_0040;
  localparam logic [19:0] MU_OUT_PORT     = 20'h0_0044;
  localparam logic [19:0] MU_LOW_LIMIT    = 20'h0_1000;
  localparam int unsigned MU_OPI_BIT      = 3;
  localparam logic [31:0] MU_EMPTY_DATA   = 32'hFFFF_FFFF;
  localparam logic [7:0]  CFG_BAR_FIRST   = 8'h10;
  localparam logic [7:0]  CFG_BAR_MOVED   = 8'h18;

  localparam logic [19:0] PTR_STEP  = 20'h0_0004;
  localparam logic [19:0] SIZE_BASE = 20'h0_0400;

  // size code n gives a queue of 1 Kbyte shifted left by n
  function automatic logic [19:0] ptr_advance(input logic [19:0] ptr,
                                              input logic [2:0]  size_sel);
    logic [19:0] mask;
    mask = (SIZE_BASE << size_sel) - PTR_STEP + 20'h0_0003;
    return (ptr & ~mask) | ((ptr + PTR_STEP) & mask);
  endfunction

  typedef struct packed {
    logic        we;
    logic [19:0] off;
    logic [31:0] data;
  } imu_pci_req_t;

  typedef struct packed {
    logic        ack;
    logic        retry;
    logic        fwd;
    logic [31:0] data;
  } imu_pci_rsp_t;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic [31:0] addr;
    logic [31:0] data;
  } imu_mem_req_t;

endpackage

/* File: core/imu_queue.sv */
`timescale 1ns/1ps
module imu_queue (
  input  wire logic        ref_clk,     // 10 MHz clock
  input  wire logic        rst,         // synchronous reset
  input  wire logic [2:0]  size_sel,    // queue size code
  input  wire logic        sw_top_we,   // software writes top pointer
  input  wire logic        sw_bot_we,   // software writes bottom pointer
  input  wire logic [19:0] sw_ptr,      // pointer value from software
  input  wire logic        hw_adv_top,  // unit advances top
  input  wire logic        hw_adv_bot,  // unit advances bottom
  output logic      [19:0] top_ptr,     // top pointer offset
  output logic      [19:0] bot_ptr,     // bottom pointer offset
  output logic             empty,       // queue empty
  output logic             full         // queue full
);

  logic [19:0] top_q;
  logic [19:0] top_d;
  logic [19:0] bot_q;
  logic [19:0] bot_d;
  logic        full_q;
  logic        full_d;

  assign top_ptr = top_q;
  assign bot_ptr = bot_q;
  assign full    = full_q;
  assign empty   = (top_q == bot_q) && !full_q;

  always_comb begin
    top_d  = top_q;
    bot_d  = bot_q;
    full_d = full_q;
    if (sw_top_we) begin
      top_d  = sw_ptr;
      // equal after a step of four from the old top means full, else empty
      full_d = (sw_ptr == bot_q) && (sw_ptr != top_q) &&
               (sw_ptr == imu_pkg::ptr_advance(top_q, size_sel));
    end
    if (sw_bot_we && (sw_ptr != bot_q)) begin
      bot_d  = sw_ptr;
      full_d = 1'b0;
    end else if (sw_bot_we) begin
      bot_d = sw_ptr;
    end
    // unit advances win over a software write in the same cycle
    if (hw_adv_top && !full_q) begin
      top_d  = imu_pkg::ptr_advance(top_q, size_sel);
      full_d = (imu_pkg::ptr_advance(top_q, size_sel) == bot_q);
    end
    if (hw_adv_bot && !empty) begin
      bot_d  = imu_pkg::ptr_advance(bot_q, size_sel);
      full_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      top_q  <= 20'h0_0000;
      bot_q  <= 20'h0_0000;
      full_q <= 1'b0;
    end else begin
      top_q  <= top_d;
      bot_q  <= bot_d;
      full_q <= full_d;
    end
  end

endmodule

/* File: tb/imu_mem_model.sv */
`timescale 1ns/1ps
module imu_mem_model (
  input  wire logic                  ref_clk,   // clock
  input  wire imu_pkg::imu_mem_req_t mem_req,   // local memory request
  output logic                       mem_ack,   // done pulse
  output logic      [31:0]           mem_rdata  // read data
);
  // ************************************************************
  // local memory with optional stalls
  // ************************************************************
  logic [31:0] mem [logic [31:0]];
  logic        slow;
  int          wait_n;

  initial begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0000_0000;
    slow = 1'b0;
    wait_n = 0;
  end

  // read data flips when not answering a read so stale values cannot pass as fresh
  always @(posedge ref_clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req.valid === 1'b1 && mem_ack !== 1'b1) begin
      if (wait_n != 0) begin
        wait_n <= wait_n - 1;
      end else begin
        mem_ack <= 1'b1;
        if (mem_req.we) mem[mem_req.addr] = mem_req.data;
        else mem_rdata <= mem[mem_req.addr];
        wait_n <= slow ? $urandom_range(3, 0) : 0;
      end
    end
  end
endmodule

/* File: tb/imu_core_monitor.sv */
`timescale 1ns/1ps
module imu_core_monitor (
  input wire logic                  ref_clk,         // clock
  input wire logic                  rst,             // reset
  input wire logic                  psel,            // apb select
  input wire logic                  penable,         // apb enable
  input wire logic                  pready,          // apb ready
  input wire logic                  pslverr,         // apb error
  input wire logic                  pci_req_valid,   // pci request held
  input wire imu_pkg::imu_pci_req_t pci_req,         // pci request
  input wire imu_pkg::imu_pci_rsp_t pci_rsp,         // pci answer
  input wire imu_pkg::imu_mem_req_t mem_req,         // memory request
  input wire logic                  mem_ack,         // memory done
  input wire logic      [31:0]      mem_rdata,       // memory read data
  input wire logic                  msg_mode,        // message mode
  input wire logic      [7:0]       cfg_regbase_off  // register bar offset
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ************************************************************
  // properties
  // ************************************************************
  property p_apb_wait;
    $rose(penable) && psel |=> pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb wait state wrong");
  property p_apb_pulse;
    pready |=> !pready;
  endproperty
  a_apb_pulse: assert property (p_apb_pulse) else $error("pready too long");
  property p_ack_pulse;
    pci_rsp.ack |=> !pci_rsp.ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("pci ack too long");
  property p_regbase;
    msg_mode == $past(msg_mode) |->
      cfg_regbase_off == (msg_mode ? imu_pkg::CFG_BAR_MOVED : imu_pkg::CFG_BAR_FIRST);
  endproperty
  a_regbase: assert property (p_regbase) else $error("register bar offset wrong");
  property p_refuse;
    pci_rsp.ack && !$past(msg_mode) |-> pci_rsp.retry;
  endproperty
  a_refuse: assert property (p_refuse) else $error("access without message mode");
  property p_low_region;
    pci_req_valid && pci_req.off >= imu_pkg::MU_LOW_LIMIT |-> !mem_req.valid;
  endproperty
  a_low_region: assert property (p_low_region) else $error("upper region used memory");
  property p_low_fwd;
    pci_rsp.ack && pci_req.off >= imu_pkg::MU_LOW_LIMIT && !pci_rsp.retry |-> pci_rsp.fwd;
  endproperty
  a_low_fwd: assert property (p_low_fwd) else $error("upper region not forwarded");
  property p_mem_hold;
    mem_req.valid && !mem_ack |=> mem_req.valid && $stable(mem_req.addr);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("memory request dropped");
  property p_mem_kind;
    $rose(mem_req.valid) |-> pci_req_valid && mem_req.we == pci_req.we &&
      (!pci_req.we || mem_req.data == pci_req.data);
  endproperty
  a_mem_kind: assert property (p_mem_kind) else $error("memory cycle kind wrong");
  property p_delayed;
    mem_ack && mem_req.valid && !mem_req.we |=>
      pci_rsp.ack && pci_rsp.data == $past(mem_rdata);
  endproperty
  a_delayed: assert property (p_delayed) else $error("port read data wrong");

  c_empty: cover property (pci_rsp.ack && pci_rsp.data == imu_pkg::MU_EMPTY_DATA);
  c_mem_wr: cover property (mem_ack && mem_req.we);
  c_retry: cover property (pci_rsp.ack && pci_rsp.retry);
  c_slverr: cover property (pslverr);
endmodule

bind imu_core imu_core_monitor u_mon (
  .ref_clk, .rst, .psel, .penable, .pready, .pslverr, .pci_req_valid,
  .pci_req, .pci_rsp, .mem_req, .mem_ack, .mem_rdata, .msg_mode, .cfg_regbase_off
);

/* File: tb/imu_core_tb.sv */
`timescale 1ns/1ps
module imu_core_tb;
  logic                  ref_clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic                  pci_req_valid, mem_ack, pci_int, lb_int, msg_mode;
  logic [11:0]           paddr;
  logic [31:0]           pwdata, prdata, mem_rdata, rd, v;
  logic [7:0]            cfg_regbase_off;
  imu_pkg::imu_pci_req_t pci_req;
  imu_pkg::imu_pci_rsp_t pci_rsp, rs;
  imu_pkg::imu_mem_req_t mem_req;
  logic [31:0]           exp_q[$];
  int                    bad_count, checked;

  imu_core dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pci_req_valid, .pci_req, .pci_rsp, .mem_req, .mem_ack,
    .mem_rdata, .pci_int, .lb_int, .msg_mode, .cfg_regbase_off);
  imu_mem_model mem_model (.ref_clk, .mem_req, .mem_ack, .mem_rdata);

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // an idle edge after each transfer keeps strobes from being driven twice at one edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic pci(input logic w, input logic [19:0] o, input logic [31:0] d,
                     output imu_pkg::imu_pci_rsp_t r);
    pci_req_valid <= 1'b1;
    pci_req <= '{we: w, off: o, data: d};
    do @(posedge ref_clk); while (pci_rsp.ack !== 1'b1);
    r = pci_rsp;
    pci_req_valid <= 1'b0;
    pci_req <= '{we: ~w, off: ~o, data: ~d};
    @(posedge ref_clk);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    close_out;
  end

  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    {rst, psel, penable, pwrite, pci_req_valid} = 5'b10000;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pci_req = '0;
    v = $urandom(32'h083180b6);
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    apb(0, imu_pkg::APB_CTRL, 0, rd);
    chk("ctrl", rd, imu_pkg::CTRL_RESET);
    chk("regbase", 32'(cfg_regbase_off), 32'(imu_pkg::CFG_BAR_FIRST));
    apb(0, 12'h0fc, 0, rd);
    chk("slverr", 32'(err), 1);
    chk("unmapped", rd, 0);
    pci(0, imu_pkg::MU_IN_PORT, 0, rs);
    chk("retry", 32'(rs.retry), 1);
    for (int q = 0; q < 4; q++) begin
      apb(1, 12'(16 + 8 * q), 32'(2048 * q), rd);
      apb(1, 12'(20 + 8 * q), 32'(2048 * q + (q == 0 ? 12 : 0)), rd);
    end
    for (int i = 0; i < 3; i++) begin
      v = $urandom | 32'h0000_1000;
      mem_model.mem[32'hA000_0000 + 4 * i] = v;
      exp_q.push_back(v);
    end
    apb(1, imu_pkg::APB_CTRL, 32'hA000_0001, rd);
    repeat (2) @(posedge ref_clk);
    chk("regbase_msg", 32'(cfg_regbase_off), 32'(imu_pkg::CFG_BAR_MOVED));
    chk("msg_mode", 32'(msg_mode), 1);
    mem_model.slow = 1'b1;
    for (int i = 0; i < 4; i++) begin
      pci(0, imu_pkg::MU_IN_PORT, 0, rs);
      chk("in_free", rs.data, exp_q.size() ? exp_q.pop_front() : imu_pkg::MU_EMPTY_DATA);
    end
    apb(0, 12'h010, 0, rd);
    chk("if_bot", rd, 32'hA000_000C);
    apb(1, imu_pkg::APB_INTEN, 1, rd);
    v = $urandom | 32'h0000_1000;
    pci(1, imu_pkg::MU_IN_PORT, v, rs);
    chk("ip_mem", mem_model.mem[32'hA000_0800], v);
    apb(0, 12'h01c, 0, rd);
    chk("ip_top", rd, 32'hA000_0804);
    chk("lb_int", 32'(lb_int), 1);
    apb(1, imu_pkg::APB_STAT, 32'h0000_0100, rd);
    repeat (2) @(posedge ref_clk);
    chk("lb_clr", 32'(lb_int), 0);
    for (int i = 0; i < 2; i++) begin
      v = $urandom;
      mem_model.mem[32'hA000_1000 + 4 * i] = v;
      exp_q.push_back(v);
    end
    apb(1, 12'h024, 32'h0000_1008, rd);
    repeat (3) @(posedge ref_clk);
    chk("pci_int", 32'(pci_int), 1);
    pci(0, imu_pkg::MU_SYS_INT_STAT, 0, rs);
    chk("sys_stat", rs.data & 8, 8);
    apb(1, imu_pkg::APB_INTEN, 3, rd);
    repeat (3) @(posedge ref_clk);
    chk("pci_mask", 32'(pci_int), 0);
    pci(1, imu_pkg::MU_SYS_INT_MASK, 0, rs);
    chk("sys_mask", rs.data & 8, 8);
    repeat (3) @(posedge ref_clk);
    chk("pci_unmask", 32'(pci_int), 1);
    apb(1, imu_pkg::APB_INTEN, 1, rd);
    for (int i = 0; i < 3; i++) begin
      pci(0, imu_pkg::MU_OUT_PORT, 0, rs);
      chk("out_post", rs.data, exp_q.size() ? exp_q.pop_front() : imu_pkg::MU_EMPTY_DATA);
    end
    repeat (3) @(posedge ref_clk);
    chk("pci_int_clr", 32'(pci_int), 0);
    apb(0, imu_pkg::APB_STAT, 0, rd);
    chk("op_stat", 32'(rd[9]), 0);
    pci(0, 20'h0_1000, 0, rs);
    chk("fwd", 32'(rs.fwd), 1);
    // the last write meets a full queue and must leave memory untouched
    mem_model.slow = 1'b0;
    for (int i = 0; i < 257; i++) begin
      v = $urandom;
      pci(1, imu_pkg::MU_OUT_PORT, v, rs);
      if (i < 256) exp_q.push_back(v);
    end
    for (int i = 0; i < 256; i++) begin
      chk("of_mem", mem_model.mem[32'hA000_1800 + 4 * i], exp_q[i]);
    end
    apb(0, 12'h02c, 0, rd);
    chk("of_top", rd, 32'hA000_1800);
    apb(1, 12'h01c, 32'h0000_0BFC, rd);
    apb(1, 12'h01c, 32'h0000_0800, rd);
    apb(0, imu_pkg::APB_STAT, 0, rd);
    chk("of_full", 32'(rd[7]), 1);
    chk("ip_full", 32'(rd[5]), 1);
    close_out;
  end
endmodule
